// >>> design/slps_consts.svh
// Constants of the sleep and suspend power controller.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef SLPS_CONSTS_SVH
`define SLPS_CONSTS_SVH
`define SLPS_IDX_SLEEP_CONTROL 8'h13
`define SLPS_BIT_ENABLE 7
`define SLPS_DIV_HI 6
`define SLPS_DIV_LO 3
`define SLPS_BIT_PIN 2
`define SLPS_BIT_KEEP 0
`define SLPS_RST_ENABLE 1'b0
`define SLPS_RST_DIV 4'h0
`define SLPS_RST_KEEP 1'b1
`define SLPS_CLK_NS 100
`define SLPS_ISA_RST_NS 2000000
`define SLPS_ISA_RST_CYC \
  ((`SLPS_ISA_RST_NS + `SLPS_CLK_NS - 1) / `SLPS_CLK_NS)
`endif

// >>> design/slps_ctrl.sv
// Sleep and suspend power controller: sleep control register,
// sleep clock divider, bus clock gating and suspend sequencer.
// Assumes all inputs synchronous to i_core_clk; the 32 kHz
// oscillator arrives as a sampled level.
`timescale 1ns/1ps
`include "slps_consts.svh"

module slps_ctrl #(
  parameter int P_ISA_RST_CYC = `SLPS_ISA_RST_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_index,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic i_sleep_req_n,
  input wire logic i_suspend_req_n,
  input wire logic i_irq,
  input wire logic i_hold_req,
  input wire logic i_refresh_done,
  input wire logic i_osc32k,
  input wire logic i_cpu_off_sel,
  input wire logic i_self_refresh_sel,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  output logic o_ior_n,
  output logic o_iow_n,
  output logic o_cpu_clk_en,
  output logic o_bus_clk_run,
  output logic o_clk_stop,
  output logic o_leak_ctl,
  output logic o_refresh_tick,
  output logic o_self_refresh,
  output logic o_isa_reset,
  output logic o_proc_reset,
  output logic o_coproc_reset,
  output slps_pkg::slps_state_t o_power_state
);
  import slps_pkg::*;

  localparam int CW = $clog2(P_ISA_RST_CYC + 1);
  localparam logic [CW-1:0] RST_LAST = CW'(P_ISA_RST_CYC - 1);

  slps_state_t state_q, state_d;
  logic enable_q, enable_d;
  logic [3:0] div_q, div_d;
  logic keep_q, keep_d;
  logic sleep_q, sleep_d;
  logic pin_q, osc_q;
  slps_div_t cnt_q, cnt_d;
  logic [CW-1:0] rst_cnt_q, rst_cnt_d;
  logic cpu_off_q, cpu_off_d;
  logic cpu_en_q, cpu_en_d;
  logic bus_run_q, bus_run_d;
  logic refr_q, refr_d;
  logic [7:0] rdata_q, rdata_d;
  logic in_susp, hit, wr, rd, set_wr, sleep_act, tick;
  logic pin_fall, pin_rise, osc_rise;
  slps_div_t divisor;

  always_comb begin
    in_susp = (state_q == SLPS_SUSP);
    hit = (i_cfg_index == `SLPS_IDX_SLEEP_CONTROL);
    // Accesses are dropped in suspend so nothing is corrupted
    wr = i_cfg_wr & hit & ~in_susp;
    rd = i_cfg_rd & hit & ~in_susp;
    set_wr = wr & i_cfg_wdata[`SLPS_BIT_ENABLE];
    pin_fall = pin_q & ~i_sleep_req_n;
    pin_rise = ~pin_q & i_sleep_req_n;
    osc_rise = ~osc_q & i_osc32k;
    divisor = slps_divisor(div_q);
    sleep_act = sleep_q & ~i_hold_req;
    enable_d = enable_q;
    div_d = div_q;
    keep_d = keep_q;
    sleep_d = sleep_q;
    if (wr) begin
      enable_d = i_cfg_wdata[`SLPS_BIT_ENABLE];
      div_d = i_cfg_wdata[`SLPS_DIV_HI:`SLPS_DIV_LO];
      keep_d = i_cfg_wdata[`SLPS_BIT_KEEP];
    end else if (i_irq && !in_susp) begin
      // Suspend keeps the register frozen even if an interrupt arrives
      enable_d = 1'b0;
    end
    if (!in_susp) begin
      if (pin_fall) begin
        sleep_d = 1'b1;
      end else if (pin_rise && !enable_q) begin
        sleep_d = 1'b0;
      end
      if (wr) begin
        sleep_d = set_wr;
      end
      // A fresh software set wins over a same-cycle interrupt
      if (i_irq && !set_wr) begin
        sleep_d = 1'b0;
      end
    end
  end

  always_comb begin
    tick = 1'b0;
    cnt_d = '0;
    if (sleep_act && !in_susp) begin
      if (cnt_q >= divisor - 11'h001) begin
        tick = 1'b1;
      end else begin
        cnt_d = cnt_q + 11'h001;
      end
    end
    cpu_en_d = ~in_susp & (~sleep_act | tick);
    bus_run_d = ~in_susp & (keep_q | ~enable_q);
    refr_d = in_susp & osc_rise;
    rdata_d = 8'h00;
    if (rd) begin
      rdata_d[`SLPS_BIT_ENABLE] = enable_q;
      rdata_d[`SLPS_DIV_HI:`SLPS_DIV_LO] = div_q;
      rdata_d[`SLPS_BIT_PIN] = i_sleep_req_n;
      rdata_d[`SLPS_BIT_KEEP] = keep_q;
    end
  end

  always_comb begin
    state_d = state_q;
    rst_cnt_d = rst_cnt_q;
    cpu_off_d = cpu_off_q;
    case (state_q)
      SLPS_RUN: begin
        if (!i_suspend_req_n) begin
          state_d = SLPS_ARM;
        end
      end
      SLPS_ARM: begin
        if (i_suspend_req_n) begin
          state_d = SLPS_RUN;
        end else if (i_refresh_done) begin
          state_d = SLPS_SUSP;
          cpu_off_d = i_cpu_off_sel;
        end
      end
      SLPS_SUSP: begin
        // Released request only counts on a 32 kHz edge
        if (osc_rise && i_suspend_req_n) begin
          state_d = SLPS_RESUME;
          rst_cnt_d = '0;
        end
      end
      SLPS_RESUME: begin
        if (rst_cnt_q == RST_LAST) begin
          state_d = SLPS_RUN;
        end else begin
          rst_cnt_d = rst_cnt_q + CW'(1);
        end
      end
      default: begin
        state_d = SLPS_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= SLPS_RUN;
      enable_q <= `SLPS_RST_ENABLE;
      div_q <= `SLPS_RST_DIV;
      keep_q <= `SLPS_RST_KEEP;
      sleep_q <= 1'b0;
      pin_q <= 1'b1;
      osc_q <= 1'b0;
      cnt_q <= '0;
      rst_cnt_q <= '0;
      cpu_off_q <= 1'b0;
      cpu_en_q <= 1'b1;
      bus_run_q <= 1'b1;
      refr_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      enable_q <= enable_d;
      div_q <= div_d;
      keep_q <= keep_d;
      sleep_q <= sleep_d;
      pin_q <= i_sleep_req_n;
      osc_q <= i_osc32k;
      cnt_q <= cnt_d;
      rst_cnt_q <= rst_cnt_d;
      cpu_off_q <= cpu_off_d;
      cpu_en_q <= cpu_en_d;
      bus_run_q <= bus_run_d;
      refr_q <= refr_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_cfg_rdata = rdata_q;
  assign o_cpu_clk_en = cpu_en_q;
  assign o_bus_clk_run = bus_run_q;
  assign o_clk_stop = (state_q == SLPS_SUSP);
  assign o_leak_ctl = (state_q == SLPS_SUSP);
  assign o_ior_n = i_ior_n | in_susp;
  assign o_iow_n = i_iow_n | in_susp;
  assign o_refresh_tick = refr_q;
  assign o_self_refresh = in_susp & i_self_refresh_sel;
  assign o_isa_reset = (state_q == SLPS_RESUME);
  // Processors only lose context when their interface was off
  assign o_proc_reset = (state_q == SLPS_RESUME) & cpu_off_q;
  assign o_coproc_reset = (state_q == SLPS_RESUME) & cpu_off_q;
  assign o_power_state = state_q;

  sequence s_resume_start;
    (state_q == SLPS_SUSP) ##1 (state_q == SLPS_RESUME);
  endsequence

  sequence s_susp_entry;
    (state_q == SLPS_ARM) ##1 (state_q == SLPS_SUSP);
  endsequence

  property p_bit_sets_sleep;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      set_wr |=> sleep_q && enable_q;
  endproperty
  a_bit_sets_sleep: assert property (p_bit_sets_sleep)
    else $error("Enable bit write did not enter sleep");

  property p_div_four;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (sleep_q && !i_hold_req && div_q == 4'h1 && cnt_q == 11'h000
       && state_q == SLPS_RUN) |=> !o_cpu_clk_en;
  endproperty
  a_div_four: assert property (p_div_four)
    else $error("Divide by four ticked too early");

  property p_pin_mirror;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      rd |=> o_cfg_rdata[2] == $past(i_sleep_req_n);
  endproperty
  a_pin_mirror: assert property (p_pin_mirror)
    else $error("Pin state bit does not mirror the pin");

  property p_pin_enters;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (pin_fall && !i_irq && !wr && !in_susp) |=> sleep_q;
  endproperty
  a_pin_enters: assert property (p_pin_enters)
    else $error("Sleep pin low did not enter sleep");

  property p_irq_exits;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_irq && !wr && !in_susp) |=> !sleep_q && !enable_q;
  endproperty
  a_irq_exits: assert property (p_irq_exits)
    else $error("Interrupt did not leave sleep");

  property p_bus_stop;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (enable_q && !keep_q) |=> !o_bus_clk_run;
  endproperty
  a_bus_stop: assert property (p_bus_stop)
    else $error("Bus clock ran in sleep without keep bit");

  property p_bus_keep;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (keep_q && state_q == SLPS_RUN) |=> o_bus_clk_run;
  endproperty
  a_bus_keep: assert property (p_bus_keep)
    else $error("Bus clock stopped with keep bit set");

  property p_susp_clocks;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_susp_entry |-> (o_clk_stop && o_leak_ctl) ##1 !o_cpu_clk_en;
  endproperty
  a_susp_clocks: assert property (p_susp_clocks)
    else $error("Clocks or leakage wrong in suspend");

  property p_hold_pauses;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (sleep_q && i_hold_req && state_q == SLPS_RUN) |=> o_cpu_clk_en;
  endproperty
  a_hold_pauses: assert property (p_hold_pauses)
    else $error("Hold request did not pause the divider");

  property p_retain;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      in_susp |=> $stable(enable_q) && $stable(div_q) && $stable(keep_q);
  endproperty
  a_retain: assert property (p_retain)
    else $error("Register changed during suspend");

  property p_resume_reset;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_resume_start |-> o_isa_reset [*8];
  endproperty
  a_resume_reset: assert property (p_resume_reset)
    else $error("Bus reset too short on resume");

endmodule : slps_ctrl

// >>> design/slps_pkg.sv
// Types of the sleep and suspend power controller.
// Assumes nothing beyond the constants header.
package slps_pkg;
  typedef enum logic [3:0] {
    SLPS_RUN = 4'h1,
    SLPS_ARM = 4'h2,
    SLPS_SUSP = 4'h4,
    SLPS_RESUME = 4'h8
  } slps_state_t;

  typedef logic [10:0] slps_div_t;

  // Reserved codes divide by one so the CPU clock stays defined
  function automatic slps_div_t slps_divisor(input logic [3:0] code);
    case (code)
      4'h0: slps_divisor = 11'h001;
      4'h1: slps_divisor = 11'h004;
      4'h2: slps_divisor = 11'h008;
      4'h3: slps_divisor = 11'h00C;
      4'h4: slps_divisor = 11'h010;
      4'h5: slps_divisor = 11'h040;
      4'h6: slps_divisor = 11'h080;
      4'h7: slps_divisor = 11'h100;
      4'h8: slps_divisor = 11'h400;
      default: slps_divisor = 11'h001;
    endcase
  endfunction : slps_divisor
endpackage : slps_pkg

// >>> verification/slps_pmu.sv
// Model of the external power management unit: sleep and suspend
// request pins plus the free running 32 kHz oscillator level.
// Assumes the bench commands it; pins change on the falling edge.
`timescale 1ns/1ps
module slps_pmu #(
  parameter int P_OSC_HALF = 8
) (
  input wire logic i_core_clk,
  input wire logic i_sleep_on,
  input wire logic i_susp_on,
  output logic o_sleep_req_n,
  output logic o_suspend_req_n,
  output logic o_osc32k
);
  int osc_cnt;
  initial begin
    o_sleep_req_n = 1'b1;
    o_suspend_req_n = 1'b1;
    o_osc32k = 1'b0;
    osc_cnt = 0;
  end
  // Oscillator runs free, also in suspend, since refresh needs it
  always @(negedge i_core_clk) begin
    o_sleep_req_n <= !i_sleep_on;
    o_suspend_req_n <= !i_susp_on;
    osc_cnt <= (osc_cnt == P_OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == P_OSC_HALF - 1) begin
      o_osc32k <= !o_osc32k;
    end
  end
endmodule : slps_pmu

// >>> verification/test_slps_ctrl.sv
// Self-checking bench for the sleep and suspend controller.
// Assumes a 10 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module test_slps_ctrl;
  import slps_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] idx = 8'h00, wd = 8'h00, rdata, v;
  logic irq = 1'b0, hold = 1'b0, ref_done = 1'b0, cpu_off = 1'b0;
  logic self_ref = 1'b0, ior_n = 1'b1, iow_n = 1'b1;
  logic slp_on = 1'b0, sus_on = 1'b0, slp_n, sus_n, osc;
  logic ior_o, iow_o, clk_en, bus_run, clk_stop, leak, tick, self_o;
  logic isa_rst, proc_rst, coproc_rst;
  slps_state_t st;
  int err_total = 0, check_count = 0, c, i;
  int divs [10] = '{1, 4, 8, 12, 16, 64, 128, 256, 1024, 1};
  always #50 clk = !clk;
  slps_pmu #(.P_OSC_HALF(8)) pmu (.i_core_clk(clk), .i_sleep_on(slp_on),
    .i_susp_on(sus_on), .o_sleep_req_n(slp_n), .o_suspend_req_n(sus_n),
    .o_osc32k(osc));
  slps_ctrl #(.P_ISA_RST_CYC(16)) uut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_index(idx), .i_cfg_wdata(wd),
    .o_cfg_rdata(rdata), .i_sleep_req_n(slp_n), .i_suspend_req_n(sus_n),
    .i_irq(irq), .i_hold_req(hold), .i_refresh_done(ref_done),
    .i_osc32k(osc), .i_cpu_off_sel(cpu_off),
    .i_self_refresh_sel(self_ref), .i_ior_n(ior_n), .i_iow_n(iow_n),
    .o_ior_n(ior_o), .o_iow_n(iow_o), .o_cpu_clk_en(clk_en),
    .o_bus_clk_run(bus_run), .o_clk_stop(clk_stop), .o_leak_ctl(leak),
    .o_refresh_tick(tick), .o_self_refresh(self_o),
    .o_isa_reset(isa_rst), .o_proc_reset(proc_rst),
    .o_coproc_reset(coproc_rst), .o_power_state(st));
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    idx = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    idx = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : rreg
  // Counts cycles with the chosen output high, current cycle first
  task automatic cnt(input int sel, input int n, output int k);
    k = 0;
    repeat (n) begin
      if ((sel == 0 && clk_en === 1'b1) || (sel == 1 && tick === 1'b1) ||
          (sel == 2 && isa_rst === 1'b1)) k++;
      @(negedge clk);
    end
  endtask : cnt
  task automatic wait_st(input slps_state_t s);
    int k;
    for (k = 0; k < 2000 && st !== s; k++) @(negedge clk);
    if (k == 2000) begin
      err_total++;
      results();
    end
  endtask : wait_st
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rreg(8'h13, v);
    chk("reset value", v, 16'h0005);
    chk("reset state", st, SLPS_RUN);
    wreg(8'h13, 8'h01);
    rreg(8'h13, v);
    chk("pin bit write", v, 16'h0005);
    rreg(8'h14, v);
    chk("unmapped read", v, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 10; i++) begin
      wreg(8'h13, {1'b1, 4'(i), 3'b000});
      cyc(4);
      cnt(0, 2 * divs[i], c);
      chk("divider pulses", 16'(c), 16'd2);
      chk("bus clock stop", bus_run, 1'b0);
      wreg(8'h13, {1'b0, 4'(i), 3'b000});
      cyc(2);
      chk("bus clock restart", bus_run, 1'b1);
      cnt(0, 4, c);
      chk("full speed", 16'(c), 16'd4);
    end
    $display("test divider done");
    wreg(8'h13, 8'h89);
    cyc(3);
    chk("bus clock kept", bus_run, 1'b1);
    hold = 1'b1;
    cyc(2);
    cnt(0, 8, c);
    chk("hold pause", 16'(c), 16'd8);
    hold = 1'b0;
    cyc(3);
    cnt(0, 8, c);
    chk("hold resume", 16'(c), 16'd2);
    irq = 1'b1;
    cyc(1);
    irq = 1'b0;
    cyc(2);
    cnt(0, 4, c);
    chk("irq exit", 16'(c), 16'd4);
    rreg(8'h13, v);
    chk("irq clears enable", v, 16'h000D);
    $display("test hold and irq done");
    slp_on = 1'b1;
    cyc(4);
    cnt(0, 8, c);
    chk("pin sleep", 16'(c), 16'd2);
    rreg(8'h13, v);
    chk("pin state low", v, 16'h0009);
    irq = 1'b1;
    cyc(1);
    irq = 1'b0;
    cyc(2);
    cnt(0, 4, c);
    chk("irq exit pin low", 16'(c), 16'd4);
    wreg(8'h13, 8'h89);
    cyc(4);
    cnt(0, 8, c);
    chk("sleep again", 16'(c), 16'd2);
    wreg(8'h13, 8'h09);
    slp_on = 1'b0;
    cyc(3);
    $display("test sleep pin done");
    wreg(8'h13, 8'h29);
    cpu_off = 1'b1;
    self_ref = 1'b1;
    ior_n = 1'b0;
    sus_on = 1'b1;
    wait_st(SLPS_ARM);
    cyc(3);
    chk("wait refresh", st, SLPS_ARM);
    ref_done = 1'b1;
    cyc(1);
    ref_done = 1'b0;
    cyc(1);
    chk("suspend state", st, SLPS_SUSP);
    chk("clocks low", {clk_stop, clk_en}, 16'h0002);
    chk("self refresh", self_o, 1'b1);
    chk("command gate", {ior_o, iow_o}, 16'h0003);
    chk("leakage", leak, 1'b1);
    wreg(8'h13, 8'h80);
    cnt(1, 32, c);
    chk("refresh ticks", 16'(c), 16'd2);
    chk("leak held", leak, 1'b1);
    sus_on = 1'b0;
    wait_st(SLPS_RESUME);
    chk("cpu resets", {proc_rst, coproc_rst}, 16'h0003);
    cnt(2, 24, c);
    chk("isa reset length", 16'(c), 16'd16);
    chk("back to run", st, SLPS_RUN);
    chk("command ungated", ior_o, 1'b0);
    rreg(8'h13, v);
    chk("state retained", v, 16'h002D);
    $display("test suspend done");
    cpu_off = 1'b0;
    self_ref = 1'b0;
    sus_on = 1'b1;
    wait_st(SLPS_ARM);
    sus_on = 1'b0;
    wait_st(SLPS_RUN);
    chk("arm released", st, SLPS_RUN);
    sus_on = 1'b1;
    wait_st(SLPS_ARM);
    ref_done = 1'b1;
    cyc(1);
    ref_done = 1'b0;
    cyc(1);
    chk("refresh select", self_o, 1'b0);
    sus_on = 1'b0;
    wait_st(SLPS_RESUME);
    chk("cpu kept", {proc_rst, coproc_rst, isa_rst}, 16'h0001);
    wait_st(SLPS_RUN);
    $display("test suspend cpu on done");
    wreg(8'h13, 8'h89);
    cyc(4);
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    chk("reset clock on", clk_en, 1'b1);
    cnt(0, 4, c);
    chk("reset exits sleep", 16'(c), 16'd4);
    rreg(8'h13, v);
    chk("reset register", v, 16'h0005);
    $display("test reset done");
    results();
  end
endmodule : test_slps_ctrl
